// ### sac_adc_ctrl.sv
// Sequencer and control registers of the successive-approximation converter.
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_bit_wr,
  input wire logic [2:0] bus_bit_idx,
  input wire logic bus_bit_val,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic standby,
  input wire logic flag_clr,
  input wire logic comp_above,
  output logic [9:0] tap_code,
  output logic sample_hold,
  output logic [2:0] channel_sel,
  output logic conv_done_irq,
  output logic conv_done_flag
);
  sac_tmr_if tif ();
  sac_pkg::sac_state_t state_reg;
  sac_pkg::sac_state_t state_next;
  logic [7:0] adc_mode_reg;
  logic [7:0] adc_mode_next;
  logic [7:0] adc_input_select_reg;
  logic [7:0] adc_input_select_next;
  logic [9:0] sar_reg;
  logic [9:0] sar_next;
  logic [9:0] sar_decided;
  logic [3:0] bit_idx_reg;
  logic samp_cnt_reg;
  logic [9:0] result_reg;
  logic comp_meta_reg;
  logic comp_sync_reg;
  logic mode_hit;
  logic sel_hit;
  logic wr_hit;
  logic conv_end;
  logic irq_reg;
  logic flag_reg;
  logic [15:0] rdata_reg;
  logic [9:0] tap_reg;
  logic sample_reg;
  logic [2:0] chan_reg;

  sac_step_timer u_timer (
    .clk(clk),
    .rst(rst),
    .tif(tif)
  );

  // Byte and single-bit writes share one decode.
  assign mode_hit = (bus_wr || bus_bit_wr) && (bus_addr == sac_pkg::MODE_ADDR);
  assign sel_hit = (bus_wr || bus_bit_wr) && (bus_addr == sac_pkg::SEL_ADDR);
  assign wr_hit = mode_hit || sel_hit;

  // Next register values; fixed-zero bits are masked so they never store.
  always_comb begin
    adc_mode_next = adc_mode_reg;
    adc_input_select_next = adc_input_select_reg;
    if (mode_hit && bus_wr) begin
      adc_mode_next = bus_wdata & sac_pkg::MODE_MASK;
    end else if (mode_hit) begin
      adc_mode_next[bus_bit_idx] = bus_bit_val;
      adc_mode_next = adc_mode_next & sac_pkg::MODE_MASK;
    end
    if (sel_hit && bus_wr) begin
      adc_input_select_next = bus_wdata & sac_pkg::SEL_MASK;
    end else if (sel_hit) begin
      adc_input_select_next[bus_bit_idx] = bus_bit_val;
      adc_input_select_next = adc_input_select_next & sac_pkg::SEL_MASK;
    end
  end

  // Control registers clear to zero on reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_mode_reg <= sac_pkg::MODE_RESET;
      adc_input_select_reg <= sac_pkg::SEL_RESET;
    end else begin
      adc_mode_reg <= adc_mode_next;
      adc_input_select_reg <= adc_input_select_next;
    end
  end

  // Step length from time select; prohibited codes fall back to the longest.
  always_comb begin
    case (adc_mode_reg[sac_pkg::TSEL_LSB +: 3])
      3'h0: tif.step_len = sac_pkg::STEP_T0;
      3'h1: tif.step_len = sac_pkg::STEP_T1;
      3'h2: tif.step_len = sac_pkg::STEP_T2;
      3'h4: tif.step_len = sac_pkg::STEP_T4;
      3'h5: tif.step_len = sac_pkg::STEP_T5;
      3'h6: tif.step_len = sac_pkg::STEP_T6;
      default: tif.step_len = sac_pkg::STEP_T0;
    endcase
  end

  // The timer runs in every active phase; any abort realigns it.
  assign tif.run = (state_reg != sac_pkg::SAC_IDLE);
  assign tif.restart = wr_hit || standby;

  // The comparator is asynchronous to clk, so it passes two flip-flops.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_above;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // Trial bit is kept when input is at or above the tap.
  always_comb begin
    sar_decided = sar_reg;
    sar_decided[bit_idx_reg] = comp_sync_reg;
  end

  // The final step's tick ends a conversion unless a write or standby collides.
  assign conv_end = (state_reg == sac_pkg::SAC_CONVERT) && tif.tick &&
                    (bit_idx_reg == 4'h0) && !wr_hit && !standby;

  // Sequencer: standby, then control writes, take priority over the steps.
  always_comb begin
    state_next = state_reg;
    sar_next = sar_reg;
    if (standby) begin
      state_next = sac_pkg::SAC_IDLE;
    end else if (wr_hit) begin
      sar_next = '0;
      state_next = adc_mode_next[sac_pkg::ENABLE_BIT] ?
                   sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
    end else begin
      case (state_reg)
        sac_pkg::SAC_IDLE: begin
          if (adc_mode_reg[sac_pkg::ENABLE_BIT]) begin
            state_next = sac_pkg::SAC_SAMPLE;
          end
        end
        sac_pkg::SAC_SAMPLE: begin
          if (!adc_mode_reg[sac_pkg::ENABLE_BIT]) begin
            state_next = sac_pkg::SAC_IDLE;
          end else if (tif.tick && samp_cnt_reg) begin
            state_next = sac_pkg::SAC_CONVERT;
            sar_next = sac_pkg::SAR_MSB;
          end
        end
        sac_pkg::SAC_CONVERT: begin
          if (!adc_mode_reg[sac_pkg::ENABLE_BIT]) begin
            state_next = sac_pkg::SAC_IDLE;
          end else if (tif.tick && bit_idx_reg == 4'h0) begin
            state_next = sac_pkg::SAC_SAMPLE;
            sar_next = sar_decided;
          end else if (tif.tick) begin
            sar_next = sar_decided;
            sar_next[bit_idx_reg - 4'h1] = 1'b1;
          end
        end
        default: begin
          state_next = sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  // State, approximation register and step bookkeeping.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= sac_pkg::SAC_IDLE;
      sar_reg <= '0;
      bit_idx_reg <= 4'h9;
      samp_cnt_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sar_reg <= sar_next;
      if (state_next != sac_pkg::SAC_CONVERT) begin
        bit_idx_reg <= 4'h9;
      end else if (state_reg == sac_pkg::SAC_CONVERT && tif.tick) begin
        bit_idx_reg <= bit_idx_reg - 4'h1;
      end
      // Only a tick inside the sample phase counts, so the tick that ends a
      // conversion cannot cut the next sample phase down to one step.
      if (state_next != sac_pkg::SAC_SAMPLE || tif.restart ||
          state_reg != sac_pkg::SAC_SAMPLE) begin
        samp_cnt_reg <= 1'b0;
      end else if (tif.tick) begin
        samp_cnt_reg <= 1'b1;
      end
    end
  end

  // Result is latched with the irq pulse; its reset value is not promised.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= conv_end;
      if (conv_end) begin
        result_reg <= sar_decided;
      end
    end
  end

  // Done flag is set by hardware, cleared only by flag_clr; set wins.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else if (conv_end) begin
      flag_reg <= 1'b1;
    end else if (flag_clr) begin
      flag_reg <= 1'b0;
    end
  end

  // Read data is captured from the old result, so a colliding read returns the old value while the update still happens.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (bus_rd) begin
      case (bus_addr)
        sac_pkg::MODE_ADDR: rdata_reg <= {8'h00, adc_mode_reg};
        sac_pkg::SEL_ADDR: rdata_reg <= {8'h00, adc_input_select_reg};
        sac_pkg::RESULT_ADDR: begin
          rdata_reg <= {result_reg, {sac_pkg::RES_PAD{1'b0}}};
        end
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  // Front-end drives come from flops; tap follows the next trial value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_reg <= '0;
      sample_reg <= 1'b0;
      chan_reg <= '0;
    end else begin
      tap_reg <= sar_next;
      sample_reg <= (state_next == sac_pkg::SAC_SAMPLE);
      chan_reg <= adc_input_select_next[sac_pkg::CHAN_WIDTH-1:0];
    end
  end

  assign bus_rdata = rdata_reg;
  assign tap_code = tap_reg;
  assign sample_hold = sample_reg;
  assign channel_sel = chan_reg;
  assign conv_done_irq = irq_reg;
  assign conv_done_flag = flag_reg;

  AST_IRQ_CAUSE: assert property (@(posedge clk) disable iff (rst)
    irq_reg |-> $past(state_reg == sac_pkg::SAC_CONVERT && tif.tick &&
                      bit_idx_reg == 4'h0 && !wr_hit)
  ) else $error("done irq without a finished conversion");

  AST_WRITE_WINS: assert property (@(posedge clk) disable iff (rst)
    wr_hit |=> !irq_reg && $stable(result_reg)
  ) else $error("control write did not block the result update");

  AST_ABORT_RESTART: assert property (@(posedge clk) disable iff (rst)
    wr_hit && !standby && adc_mode_next[sac_pkg::ENABLE_BIT]
      |=> state_reg == sac_pkg::SAC_SAMPLE && sar_reg == 10'h000
  ) else $error("write did not restart from the sample phase");

  AST_DISABLE: assert property (@(posedge clk) disable iff (rst)
    !adc_mode_reg[sac_pkg::ENABLE_BIT] && !wr_hit
      |=> state_reg == sac_pkg::SAC_IDLE
  ) else $error("converter active while disabled");

  AST_STANDBY: assert property (@(posedge clk) disable iff (rst)
    standby |=> state_reg == sac_pkg::SAC_IDLE && !sample_hold
  ) else $error("converter active in standby");

  AST_MSB_TRIAL: assert property (@(posedge clk) disable iff (rst)
    $rose(state_reg == sac_pkg::SAC_CONVERT)
      |-> sar_reg == 10'h200 && bit_idx_reg == 4'h9 && tap_code == 10'h200
  ) else $error("conversion did not start with bit 9 trial");

  AST_REPEAT: assert property (@(posedge clk) disable iff (rst)
    irq_reg && adc_mode_next[sac_pkg::ENABLE_BIT] && !standby
      |-> state_reg == sac_pkg::SAC_SAMPLE ##1 sample_hold
  ) else $error("no new conversion after completion");

  AST_STEP_STABLE: assert property (@(posedge clk) disable iff (rst)
    state_reg == sac_pkg::SAC_CONVERT && !tif.tick && !wr_hit && !standby
      |=> $stable(sar_reg)
  ) else $error("approximation changed inside a step");

  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (rst)
    flag_reg && !flag_clr |=> flag_reg
  ) else $error("done flag lost without a clear");

  AST_RESULT_PAD: assert property (@(posedge clk) disable iff (rst)
    $past(bus_rd && bus_addr == sac_pkg::RESULT_ADDR)
      |-> bus_rdata[5:0] == 6'h00 && bus_rdata[15:6] == $past(result_reg)
  ) else $error("result read not left aligned or not the old value");
endmodule
`default_nettype wire

// ### sac_adc_ctrl_tb.sv
// Self-checking testbench of the converter sequencer and its registers.
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_bit_wr = 1'b0;
  logic [2:0] bus_bit_idx = 3'h0;
  logic bus_bit_val = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic standby = 1'b0;
  logic flag_clr = 1'b0;
  wire comp_above;
  logic [9:0] tap_code;
  logic sample_hold;
  logic [2:0] channel_sel;
  logic conv_done_irq;
  logic conv_done_flag;
  logic [10:0] chan_v [8];
  logic [15:0] rdv;
  int errors = 0;
  int check_count = 0;
  int cnt;
  int steps [8] = '{12, 10, 8, 6, 5, 4, 4, 4};
  logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h6, 3'h6};
  // Expected codes of the channel levels, worked out by hand.
  logic [9:0] expv [8] = '{10'h000, 10'h001, 10'h200, 10'h200, 10'h3ff,
                           10'h155, 10'h2ab, 10'h001};

  sac_adc_ctrl i_sac_adc_ctrl (.clk(clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_bit_idx(bus_bit_idx),
    .bus_bit_val(bus_bit_val), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .standby(standby), .flag_clr(flag_clr),
    .comp_above(comp_above), .tap_code(tap_code), .sample_hold(sample_hold),
    .channel_sel(channel_sel), .conv_done_irq(conv_done_irq),
    .conv_done_flag(conv_done_flag));

  sac_analog_model i_sac_analog_model (.clk(clk), .chan_v(chan_v),
    .channel_sel(channel_sel), .sample_hold(sample_hold),
    .tap_code(tap_code), .comp_above(comp_above));

  // Levels in half steps; the ends and mid-scale probe rounding.
  initial begin
    chan_v = '{11'd0, 11'd1, 11'd1023, 11'd1024, 11'd2046, 11'd682,
               11'd1365, 11'd2};
  end

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask

  task automatic tick();
    @(negedge clk);
    cnt++;
  endtask

  // Every strobe is one cycle wide and raised on a falling edge.
  // A spare falling edge first keeps back-to-back calls from glitching it.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask

  task automatic bwr(input logic [15:0] a, input logic [2:0] i,
                     input logic v);
    @(negedge clk);
    bus_addr = a;
    bus_bit_idx = i;
    bus_bit_val = v;
    bus_bit_wr = 1'b1;
    @(negedge clk);
    bus_bit_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask

  task automatic wait_irq();
    while (conv_done_irq !== 1'b1 && cnt < 400) begin
      tick();
    end
    chk(16'(conv_done_irq), 16'h0001, "irq wait");
  endtask

  task automatic in_range(input int lo, input int hi, input string msg);
    chk(16'(cnt >= lo && cnt <= hi), 16'h0001, msg);
  endtask

  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      tick();
      hits += int'(conv_done_irq === 1'b1);
    end
    chk(16'(hits), 16'h0000, "irq while stopped");
  endtask

  task automatic flag_pulse();
    flag_clr = 1'b1;
    @(negedge clk);
    flag_clr = 1'b0;
  endtask

  // Generous watchdog; the tests need roughly 2000 cycles.
  initial begin
    #100000;
    errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rd(sac_pkg::MODE_ADDR, rdv);
    chk(rdv, 16'h0000, "mode reset");
    rd(sac_pkg::SEL_ADDR, rdv);
    chk(rdv, 16'h0000, "select reset");
    chk(16'(channel_sel), 16'h0000, "channel after reset");
    rd(16'hff90, rdv);
    chk(rdv, 16'h0000, "unmapped read");
    wr(sac_pkg::SEL_ADDR, 8'h05);
    rd(sac_pkg::SEL_ADDR, rdv);
    chk(rdv, 16'h0005, "select write");
    wr(sac_pkg::MODE_ADDR, 8'h47);
    rd(sac_pkg::MODE_ADDR, rdv);
    chk(rdv, 16'h0000, "mode unused bits");
    quiet(60);
    $display("test registers done");
    // Each time code once, then channel levels at the fastest code.
    // The model comparator settles in any step, so every code meets its rating.
    for (int i = 0; i < 8; i++) begin
      wr(sac_pkg::SEL_ADDR, 8'(i));
      wr(sac_pkg::MODE_ADDR, 8'h80 | {2'b00, codes[i], 3'b000});
      chk(16'(channel_sel), 16'(i), "channel select");
      cnt = 0;
      wait_irq();
      in_range(12 * steps[i], 12 * steps[i] + 1, "first length");
      cnt = 0;
      while (sample_hold === 1'b1 && cnt < 400) tick();
      in_range(2 * steps[i], 2 * steps[i] + 1, "sample phase");
      chk(16'(tap_code), 16'h0200, "first trial tap");
      tick();
      wait_irq();
      in_range(12 * steps[i], 12 * steps[i] + 1, "repeat length");
      rd(sac_pkg::RESULT_ADDR, rdv);
      chk(rdv, {expv[i], 6'h00}, "result code");
    end
    $display("test conversion done");
    // Only the done flag and the time to the next irq are judged after a restart; a rewrite aborts.
    repeat (20) tick();
    wr(sac_pkg::SEL_ADDR, 8'h02);
    chk(16'(conv_done_flag), 16'h0001, "flag kept");
    cnt = 0;
    wait_irq();
    in_range(48, 49, "restart after abort");
    repeat (20) tick();
    wr(sac_pkg::MODE_ADDR, 8'hb0);
    chk(16'(conv_done_flag), 16'h0001, "flag kept by mode");
    cnt = 0;
    wait_irq();
    in_range(48, 49, "mode abort");
    flag_pulse();
    chk(16'(conv_done_flag), 16'h0000, "flag cleared");
    $display("test abort done");
    // No result is read while disabled, since it may be stale.
    bwr(sac_pkg::MODE_ADDR, 3'h7, 1'b0);
    quiet(120);
    rd(sac_pkg::MODE_ADDR, rdv);
    chk(rdv, 16'h0030, "bit write clear");
    bwr(sac_pkg::SEL_ADDR, 3'h0, 1'b1);
    chk(16'(channel_sel), 16'h0003, "bit write select");
    bwr(sac_pkg::MODE_ADDR, 3'h7, 1'b1);
    cnt = 0;
    wait_irq();
    in_range(48, 49, "bit write start");
    $display("test bit access done");
    standby = 1'b1;
    quiet(150);
    chk(16'(sample_hold), 16'h0000, "standby idle");
    standby = 1'b0;
    cnt = 0;
    wait_irq();
    in_range(47, 51, "resume after standby");
    $display("test standby done");
    close_out();
  end
endmodule
`default_nettype wire

// ### sac_analog_model.sv
// Behavioural analog front end: sample-hold, tap string and comparator.
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
  input wire logic clk,
  input wire logic [10:0] chan_v [8],
  input wire logic [2:0] channel_sel,
  input wire logic sample_hold,
  input wire logic [9:0] tap_code,
  output wire logic comp_above
);
  logic [10:0] held;
  // The capacitor follows the chosen input only while sampling.
  always @(posedge clk) begin
    if (sample_hold) begin
      held <= chan_v[channel_sel];
    end
  end
  // Levels are in half steps, so tap k sits half a step below k steps.
  // The delay stands for comparator settling, so nothing is seen early.
  assign #1 comp_above = {1'b0, held} >= ({1'b0, tap_code, 1'b0} - 12'h001);
endmodule
`default_nettype wire

// ### sac_pkg.sv
// Package with the register map, reset values and timing of the converter.
// Summary of operation
// - Reset clears the mode register to zero, conversion off.
// - Mode bit 7 disables conversion at 0 and enables it at 1.
// - Time select picks 144, 120, 96, 72, 60 or 48 clock cycles.
// - Both control registers accept single-bit and whole-byte writes.
// - Channel select bits 2..0 pick input 0 to 7 in binary.
// - Reset clears input select to zero, selecting channel 0.
// - After sampling, set approximation bit 9 and drive the half tap.
// - Keep the top bit if input is above half tap, else clear.
// - Each later step sets next trial bit, keeps it when input >= tap.
// - Comparison continues down to and including bit 0.
// - After ten bits, copy result and raise the done interrupt together.
// - A new conversion starts after each one while enabled.
// - A control write aborts conversion and restarts it if enabled.
// - The result register content after reset is undefined.
// - Conversion halts while the controller is in standby.
// - Result is round-to-nearest quantisation over 1024 steps.
// - Result reads as 16 bits, left aligned, low 6 bits zero.
// - A read colliding with a result update returns the old result.
// - A control write colliding with the update blocks result and irq.
// - Mode writes never clear the done flag; software clears it.
package sac_pkg;
  localparam logic [15:0] MODE_ADDR = 16'hff80;
  localparam logic [15:0] SEL_ADDR = 16'hff84;
  localparam logic [15:0] RESULT_ADDR = 16'hff82;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] MODE_MASK = 8'hb8;
  localparam logic [7:0] SEL_MASK = 8'h07;
  localparam int ENABLE_BIT = 7;
  localparam int TSEL_LSB = 3;
  localparam int CHAN_WIDTH = 3;
  localparam int RES_BITS = 10;
  localparam int RES_PAD = 6;
  // Conversion length in main clock cycles per time select encoding.
  localparam int CYC_T0 = 144;
  localparam int CYC_T1 = 120;
  localparam int CYC_T2 = 96;
  localparam int CYC_T4 = 72;
  localparam int CYC_T5 = 60;
  localparam int CYC_T6 = 48;
  // Two steps of sampling plus ten compare steps make twelve equal steps.
  localparam int SAMPLE_STEPS = 2;
  localparam int TOTAL_STEPS = SAMPLE_STEPS + RES_BITS;
  localparam int STEP_W = 4;
  localparam logic [STEP_W-1:0] STEP_T0 = STEP_W'(CYC_T0 / TOTAL_STEPS);
  localparam logic [STEP_W-1:0] STEP_T1 = STEP_W'(CYC_T1 / TOTAL_STEPS);
  localparam logic [STEP_W-1:0] STEP_T2 = STEP_W'(CYC_T2 / TOTAL_STEPS);
  localparam logic [STEP_W-1:0] STEP_T4 = STEP_W'(CYC_T4 / TOTAL_STEPS);
  localparam logic [STEP_W-1:0] STEP_T5 = STEP_W'(CYC_T5 / TOTAL_STEPS);
  localparam logic [STEP_W-1:0] STEP_T6 = STEP_W'(CYC_T6 / TOTAL_STEPS);
  localparam logic [9:0] SAR_MSB = 10'h200;
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_SAMPLE = 3'b010,
    SAC_CONVERT = 3'b100
  } sac_state_t;
endpackage

// ### sac_step_timer.sv
// Step timer that marks the last cycle of every conversion step.
`timescale 1ns/1ps
`default_nettype none
module sac_step_timer (
  input wire logic clk,
  input wire logic rst,
  sac_tmr_if.tmr tif
);
  logic [sac_pkg::STEP_W-1:0] cnt_reg;

  // The tick is combinational so the sequencer acts on the step's last cycle.
  assign tif.tick = tif.run && !tif.restart &&
                    (cnt_reg == tif.step_len - sac_pkg::STEP_W'(1));

  // Counter wraps at each step end; a restart realigns it to the step start.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (tif.restart || !tif.run || tif.tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + sac_pkg::STEP_W'(1);
    end
  end
endmodule
`default_nettype wire

// ### sac_tmr_if.sv
// Interface between the sequencer and its step timer.
`timescale 1ns/1ps
`default_nettype none
interface sac_tmr_if;
  logic run;
  logic restart;
  logic [sac_pkg::STEP_W-1:0] step_len;
  logic tick;
  modport ctl (output run, output restart, output step_len, input tick);
  modport tmr (input run, input restart, input step_len, output tick);
endinterface
`default_nettype wire
